// [otp_id_pkg.sv]
// constants and types shared by the otp and id access block
package otp_id_pkg;

    // instruction codes taken by the command port
    localparam logic [7:0] CMD_WRITE_REGS    = 8'h01;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS1  = 8'h05;
    localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
    localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h30;
    localparam logic [7:0] CMD_READ_CONFIG1  = 8'h35;
    localparam logic [7:0] CMD_OTP_PROGRAM   = 8'h42;
    localparam logic [7:0] CMD_OTP_READ      = 8'h4b;
    localparam logic [7:0] CMD_READ_IDENT    = 8'h9f;

    // otp space geometry
    localparam int          OTP_AW       = 10;
    localparam int          OTP_BYTES    = 1024;
    localparam int          REGION_COUNT = 32;
    localparam int          REGION_BYTES = 32;
    localparam logic [9:0]  RANDOM_END   = 10'h010;
    localparam logic [9:0]  LOCK_BASE    = 10'h010;
    localparam logic [9:0]  RFU_BASE     = 10'h014;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;

    // factory random number, lsb byte at address zero (arbitrary value)
    localparam logic [127:0] FACTORY_RANDOM =
        128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;

    // identification space, byte 0 first (arbitrary values)
    localparam int           ID_BYTES = 16;
    localparam logic [127:0] ID_CONTENT =
        128'h00000000_00000000_00000000_00a55a01;

    // status register one field positions
    localparam int SR1_WIP   = 0;
    localparam int SR1_WEL   = 1;
    localparam int SR1_E_ERR = 5;
    localparam int SR1_P_ERR = 6;

    // configuration register one fields and value after reset
    localparam int         CR1_FREEZE = 0;
    localparam logic [7:0] CR1_RESET  = 8'h00;
    localparam logic [7:0] RD_RESET   = 8'h00;

    // control states of the command engine
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OTP_READ,
        ST_LOCK_CHECK,
        ST_BYTE_WRITE
    } access_state_e;

endpackage : otp_id_pkg

// [otp_port_if.sv]
// port between the command engine and the otp byte store
interface otp_port_if;
    logic [9:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [9:0] wr_addr;
    logic [7:0] wr_data;

    modport ctrl  (output rd_addr, wr_en, wr_addr, wr_data,
                   input  rd_data);
    modport store (input  rd_addr, wr_en, wr_addr, wr_data,
                   output rd_data);
endinterface : otp_port_if

// [otp_byte_store.sv]
// one-time-programmable byte array with a synchronous read port
module otp_byte_store
    import otp_id_pkg::*;
(
    input  wire logic   i_ref_clk,   // block clock
    otp_port_if.store   port         // read and program port
);

    // contents survive reset; only power-up delivery state loads them
    logic [7:0] mem [OTP_BYTES];
    logic [7:0] rd_q;

    // delivery state image
    // delivery state: random number low, everything else erased
    initial begin
        for (int i = 0; i < OTP_BYTES; i++) begin
            if (i < int'(RANDOM_END)) begin
                mem[i] = FACTORY_RANDOM[i*8 +: 8];
            end else begin
                mem[i] = ERASED_BYTE;
            end
        end
    end

    // write port; the engine only ever supplies old & new data
    always_ff @(posedge i_ref_clk) begin
        if (port.wr_en) begin
            mem[port.wr_addr] <= port.wr_data;
        end
    end

    // registered read, one edge of latency
    always_ff @(posedge i_ref_clk) begin
        rd_q <= mem[port.rd_addr];
    end

    assign port.rd_data = rd_q;

endmodule : otp_byte_store

// [otp_id_access.sv]
// command engine for the identification space and otp space
//
// Notes on behaviour
// - read ident command returns identification bytes
// - identification space never written by host
// - separate 1024-byte otp space
// - 32 regions of 32 bytes, each lockable
// - random number bytes refuse host programming
// - lock bytes 010-013, zero bit locks region
// - reserved bytes programmable, no function attached
// - delivery state erased except random number
// - regions one to 31 user programmable
// - freeze bit blocks all otp programming
// - volatile bits reset, otp bits persist
// - registers reached only by their commands
// - locked region program sets program error
module otp_id_access
    import otp_id_pkg::*;
(
    input  wire logic       i_ref_clk,    // block clock, 25 MHz
    input  wire logic       i_rst,        // sync reset, active high
    input  wire logic       i_cmd_valid,  // decoded command present
    input  wire logic [7:0] i_cmd_code,   // instruction code
    input  wire logic [9:0] i_cmd_addr,   // otp or id byte address
    input  wire logic [7:0] i_cmd_data,   // program or register data
    output logic            o_cmd_ready,  // engine idle, takes command
    output logic            o_rd_valid,   // one-cycle read answer
    output logic [7:0]      o_rd_data,    // read answer byte
    output logic            o_busy,       // program in progress
    output logic            o_prog_error, // sticky program error
    output logic            o_frozen      // otp frozen this session
);

    otp_port_if otp_port ();

    otp_byte_store u_store (
        .i_ref_clk (i_ref_clk),
        .port      (otp_port.store)
    );

    access_state_e state;
    access_state_e next_state;
    logic [9:0]    addr_q;
    logic [9:0]    next_addr_q;
    logic [7:0]    data_q;
    logic [7:0]    next_data_q;
    logic          ready;
    logic          next_ready;
    logic          rd_valid;
    logic          next_rd_valid;
    logic [7:0]    rd_data;
    logic [7:0]    next_rd_data;
    logic          busy;
    logic          next_busy;
    logic          p_err;
    logic          next_p_err;
    logic          e_err;
    logic          next_e_err;
    logic          wel;
    logic          next_wel;
    logic [7:0]    cfg1;
    logic [7:0]    next_cfg1;

    logic          take;
    logic          err_set;
    logic          err_clr;
    logic [4:0]    cmd_region;
    logic [4:0]    held_region;
    logic [9:0]    cmd_lock_addr;
    logic [7:0]    status1;
    logic          freeze;

    // decoded terms of the offered and the held command
    logic          is_prog_cmd;  // program code on the command port
    logic          in_random;    // target inside the factory number
    logic          prog_refused; // refused before the lock check
    logic          lock_bit;     // lock bit of the held region
    logic [7:0]    id_byte;      // ident byte for the offered index

    // command taken only while idle; the front end holds it otherwise
    assign take = i_cmd_valid && (state == ST_IDLE);

    // region number is the top five address bits
    assign cmd_region  = i_cmd_addr[9:5];
    assign held_region = addr_q[9:5];

    // lock byte for a region: base plus region div 8
    assign cmd_lock_addr = LOCK_BASE | {8'h00, cmd_region[4:3]};

    assign freeze = cfg1[CR1_FREEZE];

    // program code also steers the read port to the lock byte
    assign is_prog_cmd = (i_cmd_code == CMD_OTP_PROGRAM);

    // factory number fills the sixteen lowest bytes
    assign in_random = (i_cmd_addr < RANDOM_END);

    // freeze or factory range refuse before the lock check, so nothing is written
    assign prog_refused = freeze || in_random;

    // lock bit of the held region, from the lock byte read
    assign lock_bit = otp_port.rd_data[held_region[2:0]];

    // ident byte; indexes past the table read zero
    always_comb begin
        id_byte = 8'h00;
        if (int'(i_cmd_addr) < ID_BYTES) begin
            id_byte = ID_CONTENT[i_cmd_addr[3:0]*8 +: 8];
        end
    end

    // status register one image; array protection bits out of scope
    always_comb begin
        status1            = 8'h00;
        status1[SR1_WIP]   = busy;
        status1[SR1_WEL]   = wel;
        status1[SR1_E_ERR] = e_err;
        status1[SR1_P_ERR] = p_err;
    end

    // read address: lock byte for program, else the requested byte
    // the lock byte is fetched on the command edge, saving a cycle
    always_comb begin
        otp_port.rd_addr = i_cmd_addr;
        if (state == ST_IDLE) begin
            if (is_prog_cmd) begin
                otp_port.rd_addr = cmd_lock_addr;
            end
        end else begin
            otp_port.rd_addr = addr_q;
        end
    end

    // command engine next values
    always_comb begin
        next_state       = state;
        next_addr_q      = addr_q;
        next_data_q      = data_q;
        next_rd_valid    = 1'b0;
        next_rd_data     = rd_data;
        next_wel         = wel;
        next_cfg1        = cfg1;
        err_set          = 1'b0;
        err_clr          = 1'b0;
        otp_port.wr_en   = 1'b0;
        otp_port.wr_addr = addr_q;
        // stored byte can only lose ones
        otp_port.wr_data = otp_port.rd_data & data_q;

        case (state)
            ST_IDLE: begin
                if (take) begin
                    // each register has its own command
                    case (i_cmd_code)
                        CMD_READ_IDENT: begin
                            // answer from the id space, not the array
                            next_rd_valid = 1'b1;
                            next_rd_data  = id_byte;
                        end
                        CMD_READ_STATUS1: begin
                            next_rd_valid = 1'b1;
                            next_rd_data  = status1;
                        end
                        CMD_READ_CONFIG1: begin
                            next_rd_valid = 1'b1;
                            next_rd_data  = cfg1;
                        end
                        CMD_WRITE_ENABLE: begin
                            next_wel = 1'b1;
                        end
                        CMD_WRITE_DISABLE: begin
                            next_wel = 1'b0;
                        end
                        CMD_CLEAR_STATUS: begin
                            err_clr = 1'b1;
                        end
                        CMD_WRITE_REGS: begin
                            if (wel) begin
                                // freeze sticks until reset
                                // other config bits are plain storage
                                next_cfg1 = i_cmd_data;
                                next_cfg1[CR1_FREEZE] =
                                    i_cmd_data[CR1_FREEZE] | freeze;
                                next_wel = 1'b0;
                            end
                        end
                        CMD_OTP_READ: begin
                            next_addr_q = i_cmd_addr;
                            next_state  = ST_OTP_READ;
                        end
                        CMD_OTP_PROGRAM: begin
                            // no write enable latch: silently ignored
                            if (wel) begin
                                next_addr_q = i_cmd_addr;
                                next_data_q = i_cmd_data;
                                if (prog_refused) begin
                                    // refused, nothing written
                                    // write enable latch kept on failure
                                    err_set = 1'b1;
                                end else begin
                                    next_state = ST_LOCK_CHECK;
                                end
                            end
                        end
                        default: begin
                            // unknown codes are ignored
                        end
                    endcase
                end
            end
            ST_OTP_READ: begin
                // byte comes from the separate otp space
                // the byte was addressed on the command edge
                next_rd_valid = 1'b1;
                next_rd_data  = otp_port.rd_data;
                next_state    = ST_IDLE;
            end
            ST_LOCK_CHECK: begin
                // zero lock bit blocks its region
                if (!lock_bit) begin
                    err_set    = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    // reserved bytes and user regions pass
                    next_state = ST_BYTE_WRITE;
                end
            end
            ST_BYTE_WRITE: begin
                // read-modify-write of the target byte
                // old byte and-ed in, so no stored bit ever rises
                otp_port.wr_en = 1'b1;
                next_wel       = 1'b0;
                next_state     = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // set wins over a clear in the same cycle
        // so an error is never lost to a clear
        next_p_err = (p_err && !err_clr) || err_set;
        // no erase path here; flag kept for the status image
        next_e_err = e_err && !err_clr;
        next_ready = (next_state == ST_IDLE);
        next_busy  = (next_state == ST_LOCK_CHECK) ||
                     (next_state == ST_BYTE_WRITE);
    end

    // no path writes the id space; it is a constant table
    // volatile state to defaults, otp array untouched by reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state    <= ST_IDLE;
            addr_q   <= 10'h000;
            data_q   <= 8'hff;
            ready    <= 1'b1;
            rd_valid <= 1'b0;
            rd_data  <= RD_RESET;
            busy     <= 1'b0;
        end else begin
            state    <= next_state;
            addr_q   <= next_addr_q;
            data_q   <= next_data_q;
            ready    <= next_ready;
            rd_valid <= next_rd_valid;
            rd_data  <= next_rd_data;
            busy     <= next_busy;
        end
    end

    // status and config bits are volatile, cleared by reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            p_err    <= 1'b0;
            e_err    <= 1'b0;
            wel      <= 1'b0;
            cfg1     <= CR1_RESET;
        end else begin
            p_err    <= next_p_err;
            e_err    <= next_e_err;
            wel      <= next_wel;
            cfg1     <= next_cfg1;
        end
    end

    // outputs straight from the flops above
    // o_frozen is the freeze flop bit itself
    assign o_cmd_ready  = ready;
    assign o_rd_valid   = rd_valid;
    assign o_rd_data    = rd_data;
    assign o_busy       = busy;
    assign o_prog_error = p_err;
    assign o_frozen     = cfg1[CR1_FREEZE];

endmodule : otp_id_access

// [otp_id_access_props.sv]
// assertions on the otp and id access block ports
module otp_id_access_props
    import otp_id_pkg::*;
(
    input wire logic       i_ref_clk,    // block clock
    input wire logic       i_rst,        // sync reset
    input wire logic       i_cmd_valid,  // command present
    input wire logic [7:0] i_cmd_code,   // instruction code
    input wire logic [9:0] i_cmd_addr,   // byte address
    input wire logic [7:0] i_cmd_data,   // program data
    input wire logic       o_cmd_ready,  // takes command
    input wire logic       o_rd_valid,   // answer strobe
    input wire logic [7:0] o_rd_data,    // answer byte
    input wire logic       o_busy,       // program running
    input wire logic       o_prog_error, // sticky error
    input wire logic       o_frozen      // freeze level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       take;    // command accepted at this edge
    logic [7:0] id_byte; // ident byte for the offered index

    // helper terms; indexes past the table read zero
    assign take    = i_cmd_valid && o_cmd_ready;
    assign id_byte = (i_cmd_addr < ID_BYTES) ?
                     ID_CONTENT[{i_cmd_addr[3:0], 3'b000} +: 8] : 8'h00;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_ident_answer: assert property (
        take && i_cmd_code == CMD_READ_IDENT |=>
        o_rd_valid && o_rd_data == $past(id_byte))
        else $error("ident answer wrong");
    a_otp_read_lat: assert property (
        take && i_cmd_code == CMD_OTP_READ |=>
        !o_cmd_ready ##1 (o_rd_valid && o_cmd_ready))
        else $error("otp read timing wrong");
    a_random_refuse: assert property (
        take && i_cmd_code == CMD_OTP_PROGRAM &&
        i_cmd_addr < RANDOM_END |=> !o_busy)
        else $error("random byte program started");
    a_freeze_refuse: assert property (
        take && i_cmd_code == CMD_OTP_PROGRAM && o_frozen |=> !o_busy)
        else $error("program started while frozen");
    a_frozen_hold: assert property (
        o_frozen |=> o_frozen)
        else $error("freeze dropped without reset");
    a_perr_sticky: assert property (
        o_prog_error && !(take && i_cmd_code == CMD_CLEAR_STATUS)
        |=> o_prog_error) else $error("program error lost");
    a_clear_status: assert property (
        take && i_cmd_code == CMD_CLEAR_STATUS |=> !o_prog_error)
        else $error("clear status ignored");
    a_busy_bound: assert property (
        $rose(o_busy) |-> !o_cmd_ready ##[1:2] (!o_busy && o_cmd_ready))
        else $error("busy period wrong");
    a_reset_vals: assert property (
        $fell(i_rst) |-> o_cmd_ready && !o_busy && !o_prog_error &&
        !o_frozen && !o_rd_valid) else $error("reset values wrong");
endmodule : otp_id_access_props

bind otp_id_access otp_id_access_props u_otp_id_access_props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_code(i_cmd_code), .i_cmd_addr(i_cmd_addr),
    .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_busy(o_busy),
    .o_prog_error(o_prog_error), .o_frozen(o_frozen));

// [host_model.sv]
// host side model issuing commands to the block
module host_model
(
    input  wire logic  i_ref_clk, // block clock
    input  wire logic  i_ready,   // block takes command
    output logic       o_valid,   // command present
    output logic [7:0] o_code,    // instruction code
    output logic [9:0] o_addr,    // byte address
    output logic [7:0] o_data,    // program data
    output logic       o_hang     // block never answered
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle lines at time zero
    initial begin
        o_valid = 1'b0;
        o_code  = 8'h00;
        o_addr  = 10'h000;
        o_data  = 8'h00;
        o_hang  = 1'b0;
    end

    task automatic send(input logic [7:0] c, input logic [9:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        repeat ($urandom_range(2)) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        o_valid <= 1'b1;
        o_code  <= c;
        o_addr  <= a;
        o_data  <= d;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_ready !== 1'b1 && n < 20);
        // command never taken counts as a hang as well
        if (i_ready !== 1'b1) o_hang <= 1'b1;
        // released lines show inverted values, never stale ones
        o_valid <= 1'b0;
        o_code  <= ~c;
        o_addr  <= ~a;
        o_data  <= ~d;
        do begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end while (i_ready !== 1'b1 && n < 40);
        if (n >= 40) o_hang <= 1'b1;
    endtask : send
endmodule : host_model

// [tb.sv]
// self-checking bench for the otp and id access block
module tb
    import otp_id_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, valid, ready, rd_valid, busy, perr, frozen, hang;
    logic [7:0]  code, data, rd_data;
    logic [9:0]  addr;
    logic [31:0] r;
    int          error_cnt = 0;
    int          checks = 0;
    logic [7:0]  exp_q[$];

    otp_id_access u_otp_id_access (.i_ref_clk(clk), .i_rst(rst),
        .i_cmd_valid(valid), .i_cmd_code(code), .i_cmd_addr(addr),
        .i_cmd_data(data), .o_cmd_ready(ready), .o_rd_valid(rd_valid),
        .o_rd_data(rd_data), .o_busy(busy), .o_prog_error(perr),
        .o_frozen(frozen));
    host_model u_host_model (.i_ref_clk(clk), .i_ready(ready),
        .o_valid(valid), .o_code(code), .o_addr(addr), .o_data(data),
        .o_hang(hang));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic cmp_bit(string what, logic e, logic g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %b got %b", what, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_byte(string what, logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask : cmp_byte

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    // note the answer first; the monitor may see it before we return
    task automatic rd(logic [7:0] c, logic [9:0] a, logic [7:0] e);
        exp_q.push_back(e);
        u_host_model.send(c, a, 8'h00);
    endtask : rd

    // write enable, then one program command
    task automatic prog(logic [9:0] a, logic [7:0] d);
        u_host_model.send(CMD_WRITE_ENABLE, 10'h000, 8'h00);
        u_host_model.send(CMD_OTP_PROGRAM, a, d);
    endtask : prog

    task automatic print_verdict();
        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("mismatch rd_count exp 0 got %0d", exp_q.size());
        end
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    // oldest note against each answer; an unnoted answer always fails
    always @(posedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                checks++;
                error_cnt++;
                $display("mismatch rd_data exp none got %h", rd_data);
            end else begin
                cmp_byte("rd_data", exp_q.pop_front(), rd_data);
            end
        end
    end

    always @(posedge hang) begin
        error_cnt++;
        $display("mismatch cmd_ready exp 1 got timeout");
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        r   = $urandom(49223);
        do_reset();
        rd(CMD_READ_IDENT, {6'h00, r[19:16]},
           ID_CONTENT[r[19:16]*8 +: 8]);
        rd(CMD_READ_IDENT, 10'h010, 8'h00);
        for (int i = 0; i < 16; i++)
            rd(CMD_OTP_READ, i[9:0], FACTORY_RANDOM[i*8 +: 8]);
        rd(CMD_OTP_READ, 10'h013, ERASED_BYTE);
        rd(CMD_OTP_READ, 10'h3ff, ERASED_BYTE);
        prog(10'h005, 8'h00);
        cmp_bit("prog_error", 1'b1, perr);
        rd(CMD_OTP_READ, 10'h005, FACTORY_RANDOM[47:40]);
        u_host_model.send(CMD_CLEAR_STATUS, 10'h000, 8'h00);
        cmp_bit("prog_error", 1'b0, perr);
        // a second program only clears bits
        prog(10'h020, 8'ha5);
        prog(10'h020, 8'h3c);
        rd(CMD_OTP_READ, 10'h020, 8'h24);
        prog(10'h014, 8'h0f);
        rd(CMD_OTP_READ, 10'h014, 8'h0f);
        prog({5'h1e, r[4:0]}, r[15:8]);
        rd(CMD_OTP_READ, {5'h1e, r[4:0]}, r[15:8]);
        // write enable latch off: program ignored, no error
        u_host_model.send(CMD_WRITE_ENABLE, 10'h000, 8'h00);
        u_host_model.send(CMD_WRITE_DISABLE, 10'h000, 8'h00);
        rd(CMD_READ_STATUS1, 10'h000, 8'h00);
        u_host_model.send(CMD_OTP_PROGRAM, 10'h060, 8'h00);
        cmp_bit("prog_error", 1'b0, perr);
        rd(CMD_OTP_READ, 10'h060, ERASED_BYTE);
        // lock regions 1 and 31, region 1 after use
        prog(10'h010, 8'hfd);
        prog(10'h013, 8'h7f);
        prog(10'h021, 8'h00);
        rd(CMD_READ_STATUS1, 10'h000, 8'h42);
        rd(CMD_OTP_READ, 10'h021, ERASED_BYTE);
        prog(10'h3e0, 8'h00);
        rd(CMD_OTP_READ, 10'h3e0, ERASED_BYTE);
        // freeze set through the register write
        u_host_model.send(CMD_WRITE_REGS, 10'h000, 8'h01);
        cmp_bit("frozen", 1'b1, frozen);
        u_host_model.send(CMD_CLEAR_STATUS, 10'h000, 8'h00);
        prog(10'h040, 8'h00);
        cmp_bit("prog_error", 1'b1, perr);
        rd(CMD_OTP_READ, 10'h040, ERASED_BYTE);
        do_reset();
        cmp_bit("frozen", 1'b0, frozen);
        cmp_bit("prog_error", 1'b0, perr);
        rd(CMD_READ_CONFIG1, 10'h000, CR1_RESET);
        rd(CMD_OTP_READ, 10'h020, 8'h24);
        // ident bytes unchanged after all the programming above
        rd(CMD_READ_IDENT, {6'h00, r[19:16]},
           ID_CONTENT[r[19:16]*8 +: 8]);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule : tb
